// [nv_host_pkg.sv]
// constants, types and register map for the paged nonvolatile memory host controller
package nv_host_pkg;
   // clock rate and pin timing, in ns
   localparam int CLK_MHZ = 250;
   localparam int ADDR_SETUP_NS = 10; // addr_setup_seq
   localparam int ACCESS_NS = 60; // addr_access_time, plain default
   localparam int WRITE_NS = 60; // write_cycle_min share, plain default
   localparam int PRECHARGE_NS = 60; // precharge_min_time, plain default
   localparam int WAKE_NS = 1000; // wake_delay, plain default
   // least times round up, never below one cycle
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int SETUP_CYC = ns_to_cyc(ADDR_SETUP_NS);
   localparam int ACCESS_CYC = ns_to_cyc(ACCESS_NS);
   localparam int WRITE_CYC = ns_to_cyc(WRITE_NS);
   localparam int PRECHARGE_CYC = ns_to_cyc(PRECHARGE_NS);
   localparam int WAKE_CYC = ns_to_cyc(WAKE_NS);
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ADDR_OFS = 8'h04;
   localparam logic [7:0] WDATA_OFS = 8'h08;
   localparam logic [7:0] PROT_OFS = 8'h0c;
   localparam logic [7:0] RDATA_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   // control fields
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_SEQ_BIT = 2;
   localparam int CTRL_SLEEP_BIT = 3;
   localparam int CTRL_HI_BIT = 4;
   localparam int CTRL_LO_BIT = 5;
   localparam logic [5:0] CTRL_RESET = 6'h30;
   // status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ASLEEP_BIT = 2;
   localparam int STAT_WAKING_BIT = 3;
   // protection sequence: ten steps, bytes at steps 6 and 7
   localparam logic [3:0] SEQ_LAST = 4'h9;
   localparam logic [3:0] SEQ_BYTE_STEP = 4'h6;
   localparam logic [3:0] SEQ_CPL_STEP = 4'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // pins toward the memory
   typedef struct packed {
      logic [17:0] addr;
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic high_byte_sel_n;
      logic low_byte_sel_n;
      logic sleep_req_n;
      logic [15:0] dq;
      logic dq_oe;
   } mem_pins_type;
   localparam mem_pins_type PINS_RESET = '{18'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0, 1'b0};
   // one step of the protection sequence
   typedef struct packed {
      logic [17:0] addr;
      logic write;
   } seq_step_type;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SETUP = 7'h02,
      ST_ACT = 7'h04,
      ST_WEND = 7'h08,
      ST_PRE = 7'h10,
      ST_SLEEP = 7'h20,
      ST_WAKE = 7'h40
   } eng_state_type;
endpackage

// [nv_host_ctrl.sv]
// host controller driving a paged nonvolatile memory port, run from axi4-lite registers
// Function
// - write ends at first rising strobe, data held
// - one write strobe pulse per write
// - low address bits pick page column
// - select high for precharge time between accesses
// - sleep only after access finished
// - wait wake delay after leaving sleep
// - six unlock reads in fixed order
// - protection byte written on low lane
// - complement write follows protection byte
// - finish with write 0ff00h, read 00000h
// - select high entering sequence, else 00000h
// - address setup 10 ns, stable under select
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl
   import nv_host_pkg::*;
#(
   parameter int CNT_W = 12 // width of the pin timing counter
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // memory pins; dq is split into in, out and enable
   output mem_pins_type mem_o,
   input wire logic [15:0] dq_i
);
   // wake, access, write and precharge intervals must fit the counter; refused at elaboration
   if (WAKE_CYC >= (1 << CNT_W) || ACCESS_CYC >= (1 << CNT_W) ||
       WRITE_CYC >= (1 << CNT_W) || PRECHARGE_CYC >= (1 << CNT_W)) begin : g_cnt_check
      $error("CNT_W too small for pin timing");
   end
   localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC - 1);
   localparam logic [CNT_W-1:0] ACCESS_LD = CNT_W'(ACCESS_CYC - 1);
   localparam logic [CNT_W-1:0] WRITE_LD = CNT_W'(WRITE_CYC - 1);
   localparam logic [CNT_W-1:0] PRE_LD = CNT_W'(PRECHARGE_CYC - 1);
   localparam logic [CNT_W-1:0] WAKE_LD = CNT_W'(WAKE_CYC - 1);

   // byte-enable merge used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // fixed protection sequence; steps 0-5 unlock, 6-8 writes, 9 closing read
   function automatic seq_step_type seq_entry(input logic [3:0] step);
      seq_step_type e;
      unique case (step)
         4'h0: e = '{18'h24555, 1'b0};
         4'h1: e = '{18'h3aaaa, 1'b0};
         4'h2: e = '{18'h02333, 1'b0};
         4'h3: e = '{18'h1cccc, 1'b0};
         4'h4: e = '{18'h000ff, 1'b0};
         4'h5: e = '{18'h3ef00, 1'b0};
         4'h6: e = '{18'h3aaaa, 1'b1};
         4'h7: e = '{18'h1cccc, 1'b1};
         4'h8: e = '{18'h0ff00, 1'b1};
         default: e = '{18'h00000, 1'b0};
      endcase
      return e;
   endfunction

   // bus-side state
   logic aw_full_reg, aw_full_next; // write address captured
   logic w_full_reg, w_full_next; // write data captured
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [5:0] ctrl_reg, ctrl_next; // stored control bits
   logic [17:0] addr_reg, addr_next; // target word address
   logic [15:0] wdata_reg, wdata_next; // word to write
   logic [7:0] prot_reg, prot_next; // protection byte to program
   logic cmd_go, cmd_seq; // one-cycle commands to the engine

   // engine state
   eng_state_type state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   mem_pins_type pins_reg, pins_next;
   logic op_write_reg, op_write_next; // current access is a write
   logic seq_reg, seq_next; // running the protection sequence
   logic [3:0] step_reg, step_next;
   logic [15:0] rd_reg, rd_next; // last word read
   logic done_reg, done_next; // sticky completion flag

   // register file and axi4-lite handshakes
   always_comb begin
      logic [31:0] m;
      m = merge(32'h0, w_data_reg, w_strb_reg);
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      ctrl_next = ctrl_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      prot_next = prot_reg;
      cmd_go = 1'b0;
      cmd_seq = 1'b0;
      // address and data taken in either order
      if (s_axi_awvalid_i && awready_reg) begin
         aw_full_next = 1'b1;
         aw_addr_next = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
         w_full_next = 1'b1;
         w_data_next = s_axi_wdata_i;
         w_strb_next = s_axi_wstrb_i;
      end
      if (bvalid_reg && s_axi_bready_i) begin
         bvalid_next = 1'b0;
      end
      // both halves present: commit and answer
      if (aw_full_reg && w_full_reg) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         unique case (aw_addr_reg)
            CTRL_OFS: begin
               ctrl_next = 6'(merge({26'h0, ctrl_reg}, w_data_reg, w_strb_reg));
               ctrl_next[CTRL_GO_BIT] = 1'b0;
               ctrl_next[CTRL_SEQ_BIT] = 1'b0;
               // commands while busy are dropped; status shows busy
               cmd_go = m[CTRL_GO_BIT] && state_reg == ST_IDLE;
               cmd_seq = m[CTRL_SEQ_BIT] && state_reg == ST_IDLE;
            end
            ADDR_OFS: addr_next = 18'(merge({14'h0, addr_reg}, w_data_reg, w_strb_reg));
            WDATA_OFS: wdata_next = 16'(merge({16'h0, wdata_reg}, w_data_reg, w_strb_reg));
            PROT_OFS: prot_next = 8'(merge({24'h0, prot_reg}, w_data_reg, w_strb_reg));
            RDATA_OFS, STATUS_OFS: bresp_next = RESP_OKAY; // read-only, write ignored
            default: bresp_next = RESP_SLVERR; // unmapped
         endcase
      end
      // reads answer the cycle after the address is taken
      if (rvalid_reg && s_axi_rready_i) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid_i && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         unique case (s_axi_araddr_i)
            CTRL_OFS: rdata_next = {26'h0, ctrl_reg};
            ADDR_OFS: rdata_next = {14'h0, addr_reg};
            WDATA_OFS: rdata_next = {16'h0, wdata_reg};
            PROT_OFS: rdata_next = {24'h0, prot_reg};
            RDATA_OFS: rdata_next = {16'h0, rd_reg};
            STATUS_OFS: rdata_next = {28'h0, state_reg == ST_WAKE, state_reg == ST_SLEEP,
                                      done_reg, state_reg != ST_IDLE};
            default: begin
               rdata_next = 32'h0;
               rresp_next = RESP_SLVERR;
            end
         endcase
      end
      // one transfer at a time on each side
      awready_next = !aw_full_next && !bvalid_next && !(aw_full_reg && w_full_reg);
      wready_next = !w_full_next && !bvalid_next && !(aw_full_reg && w_full_reg);
      arready_next = !rvalid_next;
   end

   // bus-side registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0;
         ctrl_reg <= CTRL_RESET;
         addr_reg <= 18'h0;
         wdata_reg <= 16'h0;
         prot_reg <= 8'h0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         prot_reg <= prot_next;
      end
   end

   // pin engine: setup, select, strobe, release, precharge
   always_comb begin
      seq_step_type e;
      e = seq_entry((state_reg == ST_IDLE) ? 4'h0 : step_reg + 4'h1); // step about to start
      state_next = state_reg;
      cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - CNT_W'(1);
      pins_next = pins_reg;
      op_write_next = op_write_reg;
      seq_next = seq_reg;
      step_next = step_reg;
      rd_next = rd_reg;
      done_next = done_reg;
      unique case (state_reg)
         ST_IDLE: begin
            // select is high here, so the sequence never needs the 00000h lead-in
            if (ctrl_reg[CTRL_SLEEP_BIT]) begin
               pins_next.sleep_req_n = 1'b0;
               state_next = ST_SLEEP;
            end else if (cmd_go || cmd_seq) begin
               done_next = 1'b0;
               seq_next = cmd_seq;
               step_next = 4'h0;
               // write bit comes with the go bit in the same commit, so take the new value
               op_write_next = cmd_seq ? e.write : ctrl_next[CTRL_WRITE_BIT];
               pins_next.addr = cmd_seq ? e.addr : addr_reg;
               cnt_next = SETUP_LD;
               state_next = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // address settles before select falls
            if (cnt_reg == '0) begin
               pins_next.cs_n = 1'b0;
               pins_next.high_byte_sel_n = seq_reg ? 1'b0 : !ctrl_reg[CTRL_HI_BIT];
               pins_next.low_byte_sel_n = seq_reg ? 1'b0 : !ctrl_reg[CTRL_LO_BIT];
               if (op_write_reg) begin
                  // strobe low with select: memory never drives the bus
                  pins_next.we_n = 1'b0;
                  pins_next.dq_oe = 1'b1;
                  pins_next.dq = !seq_reg ? wdata_reg :
                                 (step_reg == SEQ_BYTE_STEP) ? {8'h0, prot_reg} :
                                 (step_reg == SEQ_CPL_STEP) ? {8'h0, ~prot_reg} : 16'h0;
                  cnt_next = WRITE_LD;
               end else begin
                  pins_next.oe_n = 1'b0;
                  cnt_next = ACCESS_LD;
               end
               state_next = ST_ACT;
            end
         end
         ST_ACT: begin
            // full access time elapses before data is sampled or the write ends
            if (cnt_reg == '0) begin
               pins_next.cs_n = 1'b1;
               if (op_write_reg) begin
                  state_next = ST_WEND;
               end else begin
                  pins_next.oe_n = 1'b1;
                  // unlock reads come back as ordinary data
                  rd_next = {pins_reg.high_byte_sel_n ? 8'h0 : dq_i[15:8],
                             pins_reg.low_byte_sel_n ? 8'h0 : dq_i[7:0]};
                  pins_next.high_byte_sel_n = 1'b1;
                  pins_next.low_byte_sel_n = 1'b1;
                  cnt_next = PRE_LD;
                  state_next = ST_PRE;
               end
            end
         end
         ST_WEND: begin
            // data held through the select rise, released with the strobe
            pins_next.we_n = 1'b1;
            pins_next.dq_oe = 1'b0;
            pins_next.high_byte_sel_n = 1'b1;
            pins_next.low_byte_sel_n = 1'b1;
            cnt_next = PRE_LD;
            state_next = ST_PRE;
         end
         ST_PRE: begin
            // select stays high for the precharge time; every access reopens the row
            if (cnt_reg == '0) begin
               if (seq_reg && step_reg != SEQ_LAST) begin
                  // steps run back to back, no other access slips in
                  step_next = step_reg + 4'h1;
                  op_write_next = e.write;
                  pins_next.addr = e.addr;
                  cnt_next = SETUP_LD;
                  state_next = ST_SETUP;
               end else begin
                  seq_next = 1'b0;
                  done_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_SLEEP: begin
            if (!ctrl_reg[CTRL_SLEEP_BIT]) begin
               pins_next.sleep_req_n = 1'b1;
               cnt_next = WAKE_LD;
               state_next = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // no access until the wake delay has run out
            if (cnt_reg == '0) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // engine registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         pins_reg <= PINS_RESET;
         op_write_reg <= 1'b0;
         seq_reg <= 1'b0;
         step_reg <= 4'h0;
         rd_reg <= 16'h0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pins_reg <= pins_next;
         op_write_reg <= op_write_next;
         seq_reg <= seq_next;
         step_reg <= step_next;
         rd_reg <= rd_next;
         done_reg <= done_next;
      end
   end

   // outputs straight from flops
   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign mem_o = pins_reg;
endmodule // nv_host_ctrl
`default_nettype wire

// [nv_host_ctrl_properties.sv]
// pin timing checker for the host controller, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module nv_host_checker
   import nv_host_pkg::*;
#(
   parameter int CNT_W = 12 // width of the pin timing counter
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // memory pins
   input wire mem_pins_type mem_o
);
   int hi_cnt; // cycles with select high
   int awake_cnt; // cycles since sleep left
   // both counters saturate so a long idle never wraps
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hi_cnt <= 4096;
         awake_cnt <= 4096;
      end else begin
         hi_cnt <= !mem_o.cs_n ? 0 : (hi_cnt < 4096) ? hi_cnt + 1 : hi_cnt;
         awake_cnt <= !mem_o.sleep_req_n ? 0 : (awake_cnt < 4096) ? awake_cnt + 1 : awake_cnt;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   property p_data_hold;
      !mem_o.cs_n && !mem_o.we_n |=> mem_o.dq_oe && $stable(mem_o.dq);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("write data moved early");
   property p_one_pulse;
      $rose(mem_o.cs_n) && !mem_o.we_n |=> mem_o.we_n && !mem_o.dq_oe;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("strobe not ended");
   property p_precharge;
      $fell(mem_o.cs_n) |-> hi_cnt >= PRECHARGE_CYC;
   endproperty
   a_precharge: assert property (p_precharge) else $error("select high too short");
   property p_addr_still;
      !mem_o.cs_n && !$past(mem_o.cs_n) |-> $stable(mem_o.addr);
   endproperty
   a_addr_still: assert property (p_addr_still) else $error("address moved");
   property p_addr_setup;
      $fell(mem_o.cs_n) |-> $past(mem_o.addr, 2) == mem_o.addr;
   endproperty
   a_addr_setup: assert property (p_addr_setup) else $error("address setup short");
   property p_sleep_idle;
      !mem_o.sleep_req_n |-> mem_o.cs_n && mem_o.we_n && !mem_o.dq_oe;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle) else $error("access while asleep");
   property p_wake;
      $fell(mem_o.cs_n) |-> awake_cnt >= WAKE_CYC;
   endproperty
   a_wake: assert property (p_wake) else $error("access too soon after wake");
   property p_no_fight;
      mem_o.dq_oe |-> !mem_o.we_n && mem_o.oe_n;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("data bus contention");
   // main scenarios reached
   c_write: cover property ($rose(mem_o.cs_n) && !mem_o.we_n);
   c_read: cover property ($rose(mem_o.cs_n) && mem_o.we_n);
   c_sleep: cover property ($fell(mem_o.sleep_req_n));
endmodule // nv_host_checker
bind nv_host_ctrl nv_host_checker #(.CNT_W(CNT_W)) chk (
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .mem_o(mem_o)
);
`default_nettype wire

// [nv_mem_model.sv]
// behavioural model of the paged nonvolatile memory with sector protection
`timescale 1ns/100ps
`default_nettype none
module nv_mem_model
   import nv_host_pkg::*;
#(
   parameter int LAT = 10 // cycles of select low before read data is valid
) (
   // pins from the controller
   input wire logic clk_i,
   input wire mem_pins_type pins_i,
   // data back and protection flags
   output logic [15:0] dq_o,
   output logic [7:0] prot_o
);
   logic [15:0] mem [logic [17:0]]; // sparse array, 16-bit words at 18-bit addresses
   logic [17:0] seq_addr [6] = '{18'h24555, 18'h3aaaa, 18'h02333, 18'h1cccc, 18'h000ff, 18'h3ef00};
   logic [15:0] rd; // word at the live address
   logic [15:0] last = 16'h0; // last bus value
   logic [7:0] pend; // pending protection byte
   logic cs_q = 1'b1;
   logic ok;
   int lo_cnt = 0;
   int step = 0;
   // unwritten words hold a known pattern
   function automatic logic [15:0] fill(input logic [17:0] a);
      return a[15:0] ^ 16'h5a5a;
   endfunction
   initial prot_o = 8'h00;
   // live address: a column or row change just reads the new word
   always @* begin
      rd = mem.exists(pins_i.addr) ? mem[pins_i.addr] : fill(pins_i.addr);
      ok = pins_i.sleep_req_n && !pins_i.cs_n && pins_i.we_n && !pins_i.oe_n;
      ok = ok && lo_cnt >= LAT;
      // a released lane flips every cycle, never holds the old value
      dq_o[15:8] = (ok && !pins_i.high_byte_sel_n) ? rd[15:8] : ~last[15:8];
      dq_o[7:0] = (ok && !pins_i.low_byte_sel_n) ? rd[7:0] : ~last[7:0];
   end
   // end of access: commit a write, step the protection machine
   task automatic finish_access();
      logic [17:0] a;
      logic [15:0] w;
      logic wr;
      logic keep;
      a = pins_i.addr;
      wr = !pins_i.we_n;
      keep = wr && step < 6;
      if (!wr && step < 6 && a == seq_addr[step]) step = step + 1;
      else if (wr && step == 6) begin
         pend = pins_i.dq[7:0];
         step = 7;
      end else begin
         if (wr && step == 7 && pins_i.dq[7:0] == ~pend) prot_o = pend;
         step = (!wr && a == seq_addr[0]) ? 1 : 0;
      end
      w = mem.exists(a) ? mem[a] : fill(a);
      if (!pins_i.high_byte_sel_n) w[15:8] = pins_i.dq[15:8];
      if (!pins_i.low_byte_sel_n) w[7:0] = pins_i.dq[7:0];
      if (keep && !prot_o[a[17:15]]) mem[a] = w;
   endtask
   // pins sampled each clock; asleep every pin is ignored
   always @(posedge clk_i) begin
      last <= dq_o;
      cs_q <= pins_i.cs_n;
      lo_cnt <= (pins_i.cs_n || !pins_i.sleep_req_n) ? 0 : lo_cnt + 1;
      if (pins_i.sleep_req_n && pins_i.cs_n && !cs_q) finish_access();
   end
endmodule // nv_mem_model
`default_nettype wire

// [nv_host_ctrl_bench.sv]
// self-checking bench: controller over axi4-lite against the memory model
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl_bench;
   import nv_host_pkg::*;
   // one row: write a word, read it back
   typedef struct {
      logic [17:0] addr;
      logic [15:0] wd;
      logic [1:0] wl;
      logic [1:0] rl;
      logic [15:0] exp;
   } row_type;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [7:0] prot;
   logic [15:0] dq_i;
   mem_pins_type mem_o;
   int num_errors = 0;
   int checks_done = 0;
   logic [31:0] rst_vals [6] = '{32'h30, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   row_type rows [5] = '{'{18'h00005, 16'h1234, 2'b11, 2'b11, 16'h1234},
      '{18'h3ffff, 16'hbeef, 2'b11, 2'b11, 16'hbeef}, '{18'h10002, 16'habcd, 2'b10, 2'b11, 16'hab58},
      '{18'h10002, 16'hffff, 2'b00, 2'b01, 16'h0058}, '{18'h20001, 16'h00ff, 2'b01, 2'b10, 16'h5a00}};
   row_type prows [4] = '{'{18'h18004, 16'h1111, 2'b11, 2'b11, 16'hda5e},
      '{18'h28000, 16'h2222, 2'b11, 2'b11, 16'h2222}, '{18'h3aaaa, 16'h0, 2'b00, 2'b11, 16'hf0f0},
      '{18'h1cccc, 16'h0, 2'b00, 2'b11, 16'h9696}};
   always #2 sys_clk_i = ~sys_clk_i;
   nv_host_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .mem_o(mem_o), .dq_i(dq_i));
   nv_mem_model #(.LAT(10)) mem_model (.clk_i(sys_clk_i), .pins_i(mem_o), .dq_o(dq_i),
      .prot_o(prot));
   // compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checks_done++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // axi write: both channels offered, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid && !awready || wvalid && !wready);
      do @(posedge sys_clk_i); while (!bvalid);
      bready <= 1'b0;
      check(64'(bresp), 64'(er));
   endtask
   // axi read: rready held until rvalid seen
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge sys_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk_i); while (!arready);
      arvalid <= 1'b0;
      do @(posedge sys_clk_i); while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      check(64'(rresp), 64'(er));
   endtask
   // one memory access, polled to completion; done is sticky so busy is checked too
   task automatic access(input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln,
         input logic w);
      wr(ADDR_OFS, 32'(a), RESP_OKAY);
      wr(WDATA_OFS, 32'(d), RESP_OKAY);
      wr(CTRL_OFS, 32'({ln[0], ln[1], 2'b00, w, 1'b1}), RESP_OKAY);
      do rd(STATUS_OFS, RESP_OKAY, rv); while (rv[1:0] !== 2'b10);
   endtask
   task automatic run_row(input row_type r);
      access(r.addr, r.wd, r.wl, 1'b1);
      access(r.addr, 16'h0, r.rl, 1'b0);
      rd(RDATA_OFS, RESP_OKAY, rv);
      check(64'(rv), 64'(r.exp));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk_i);
      check(64'(mem_o), 64'(PINS_RESET));
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      // hand-written cases start here; a second reset restores the register defaults
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      foreach (rst_vals[i]) begin
         rd(8'(4 * i), RESP_OKAY, rv);
         check(64'(rv & 32'h3f), 64'(rst_vals[i] & ((i > 3) ? 32'h0 : 32'hffffffff)));
      end
      wr(8'h18, 32'h1, RESP_SLVERR);
      rd(8'h18, RESP_SLVERR, rv);
      check(64'(rv), 64'h0);
      $display("register map test done");
      // protect sectors 3 and 4, then probe sectors 3, 5 and 7
      wr(PROT_OFS, 32'h18, RESP_OKAY);
      wr(CTRL_OFS, 32'h34, RESP_OKAY);
      do rd(STATUS_OFS, RESP_OKAY, rv); while (rv[1:0] !== 2'b10);
      check(64'(prot), 64'h18);
      foreach (prows[i]) run_row(prows[i]);
      $display("protection test done");
      // sleep, wake, then access again
      wr(CTRL_OFS, 32'h38, RESP_OKAY);
      rd(STATUS_OFS, RESP_OKAY, rv);
      check(64'({mem_o.sleep_req_n, rv[STAT_ASLEEP_BIT]}), 64'h1);
      wr(CTRL_OFS, 32'h30, RESP_OKAY);
      do rd(STATUS_OFS, RESP_OKAY, rv); while (rv[3:2] !== 2'b00);
      run_row(rows[0]);
      $display("sleep test done");
      final_report();
   end
   // watchdog far beyond the expected few thousand cycles
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
endmodule // nv_host_ctrl_bench
`default_nettype wire
